// File: design/amc_mode_regs.sv
`timescale 1ns/10ps
module amc_mode_regs import amc_pkg::*; (
  // clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // serial programming port
  input wire logic csN,
  input wire logic sck,
  input wire logic sdi,
  output logic sdoOut,
  output logic sdoOeN,
  // decoded controls
  output logic signedFormatSelect,
  output logic [NUM_CH-1:0] channelPowerDown,
  output logic sleepActive,
  output logic [2:0] driverCurrentSelect,
  output logic internalTerminationEnable,
  output logic doubleCurrent,
  output logic outputDisable,
  output logic [2:0] laneSerializationSelect,
  output logic patternOutputEnable,
  output logic [PAT_BITS-1:0] patternWord
);
  // ****************************************
  // pin sampling
  // ****************************************
  logic csNS, sckS, sdiS;
  amc_sync #(.WIDTH(3)) uSync (
    .mclk(mclk),
    .arst_n(arst_n),
    .async({csN, sck, sdi}),
    .synced({csNS, sckS, sdiS})
  );

  logic sckPrev_q;
  logic sckRise;
  // edge detect on synchronised clock only
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      sckPrev_q <= 1'b0;
    end else begin
      sckPrev_q <= sckS;
    end
  end
  assign sckRise = sckS && !sckPrev_q && !csNS;

  // ****************************************
  // shift register and bit count
  // ****************************************
  logic [WORD_BITS-1:0] shift_q;
  logic [4:0] count_q;
  logic wordDone;
  assign wordDone = sckRise && (count_q == 5'(WORD_BITS - 1));

  // count stops at 16 so later edges are ignored
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      count_q <= '0;
      shift_q <= '0;
    end else if (csNS) begin
      count_q <= '0;
    end else if (sckRise && count_q < 5'(WORD_BITS)) begin
      count_q <= count_q + 5'd1;
      shift_q <= {shift_q[WORD_BITS-2:0], sdiS};
    end
  end

  // full word as seen at the 16th edge
  logic [WORD_BITS-1:0] word;
  assign word = {shift_q[WORD_BITS-2:0], sdiS};
  logic isRead;
  logic [6:0] addr;
  logic [7:0] wdata;
  assign isRead = word[RW_POS];
  assign addr = word[ADDR_MSB:ADDR_LSB];
  assign wdata = word[DATA_MSB:0];

  // ****************************************
  // mode registers
  // ****************************************
  logic [7:0] fmtPwr_q, outMode_q, patHigh_q, patLow_q;
  logic softReset;
  assign softReset = wordDone && !isRead && addr == ADDR_RESET && wdata[RESET_BIT];

  // writes commit only at the 16th edge; reads leave state alone
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      fmtPwr_q <= REG_RESET_VAL;
      outMode_q <= REG_RESET_VAL;
      patHigh_q <= REG_RESET_VAL;
      patLow_q <= REG_RESET_VAL;
    end else if (softReset) begin
      fmtPwr_q <= REG_RESET_VAL;
      outMode_q <= REG_RESET_VAL;
      patHigh_q <= REG_RESET_VAL;
      patLow_q <= REG_RESET_VAL;
    end else if (wordDone && !isRead) begin
      unique case (addr)
        ADDR_FMT_PWR: fmtPwr_q <= wdata;
        ADDR_OUT_MODE: outMode_q <= wdata;
        ADDR_PAT_HIGH: begin
          patHigh_q <= wdata;
          patHigh_q[PAT_HI_MASK_BIT] <= 1'b0;
        end
        ADDR_PAT_LOW: patLow_q <= wdata;
        default: ;
      endcase
    end
  end

  // ****************************************
  // read back on open-drain output
  // ****************************************
  // at the 8th edge the address sits in the low seven bits of the word, not yet at its final place
  logic [6:0] rdAddr;
  assign rdAddr = word[ADDR_LSB-2:0];
  logic [7:0] rdata;
  always_comb begin
    unique case (rdAddr)
      ADDR_FMT_PWR: rdata = fmtPwr_q;
      ADDR_OUT_MODE: rdata = outMode_q;
      ADDR_PAT_HIGH: rdata = patHigh_q;
      ADDR_PAT_LOW: rdata = patLow_q;
      default: rdata = REG_RESET_VAL;
    endcase
  end

  // address known after 8th edge; data bits follow MSB first
  logic [7:0] rdShift_q;
  logic rdActive_q;
  logic addrDone;
  assign addrDone = sckRise && count_q == 5'(ADDR_LSB - 1);
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rdShift_q <= '0;
      rdActive_q <= 1'b0;
    end else if (csNS) begin
      rdActive_q <= 1'b0;
    end else if (addrDone) begin
      rdActive_q <= shift_q[ADDR_LSB-2];
      rdShift_q <= rdata;
    end else if (sckRise && rdActive_q) begin
      rdShift_q <= {rdShift_q[6:0], 1'b0};
      if (count_q == 5'(WORD_BITS - 1)) begin
        rdActive_q <= 1'b0;
      end
    end
  end

  // low-going enable pulls the line; released means high via pull-up
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      sdoOut <= 1'b0;
      sdoOeN <= 1'b1;
    end else begin
      sdoOut <= 1'b0;
      sdoOeN <= !(rdActive_q && !rdShift_q[DATA_MSB]);
    end
  end

  // ****************************************
  // decoded controls, registered
  // ****************************************
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      signedFormatSelect <= 1'b0;
      channelPowerDown <= '0;
      sleepActive <= 1'b0;
    end else begin
      signedFormatSelect <= fmtPwr_q[SIGNED_BIT];
      sleepActive <= fmtPwr_q[SLEEP_BIT];
      // sleep overrides naps; zeros mean normal operation
      channelPowerDown <= fmtPwr_q[SLEEP_BIT] ? '1 : fmtPwr_q[NAP_MSB:0];
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      driverCurrentSelect <= '0;
      internalTerminationEnable <= 1'b0;
      doubleCurrent <= 1'b0;
      outputDisable <= 1'b0;
      laneSerializationSelect <= '0;
    end else begin
      driverCurrentSelect <= outMode_q[CUR_MSB:CUR_LSB];
      internalTerminationEnable <= outMode_q[TERM_BIT];
      // datapath relies on host for legal current with termination
      doubleCurrent <= outMode_q[TERM_BIT];
      outputDisable <= outMode_q[OFF_BIT];
      laneSerializationSelect <= outMode_q[LANE_MSB:0];
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      patternOutputEnable <= 1'b0;
      patternWord <= '0;
    end else begin
      patternOutputEnable <= patHigh_q[PAT_EN_BIT];
      patternWord <= {patHigh_q[PAT_HI_MSB:0], patLow_q};
    end
  end

  // ****************************************
  // checks
  // ****************************************
  a_sleep_all_down: assert property (@(posedge mclk) disable iff (!arst_n)
    $past(fmtPwr_q[SLEEP_BIT]) |-> channelPowerDown == '1)
    else $error("sleep did not power down all channels");
  a_nap_per_chan: assert property (@(posedge mclk) disable iff (!arst_n)
    !$past(fmtPwr_q[SLEEP_BIT]) |-> channelPowerDown == $past(fmtPwr_q[NAP_MSB:0]))
    else $error("nap bits not mapped to channels");
  a_no_write_early: assert property (@(posedge mclk) disable iff (!arst_n)
    !wordDone |=> $stable(outMode_q))
    else $error("register changed without complete word");
  a_read_no_change: assert property (@(posedge mclk) disable iff (!arst_n)
    (wordDone && isRead) |=> $stable(patLow_q) && $stable(fmtPwr_q))
    else $error("read changed a register");
  a_soft_reset: assert property (@(posedge mclk) disable iff (!arst_n)
    softReset |=> fmtPwr_q == '0 && outMode_q == '0 && patHigh_q == '0)
    else $error("soft reset left bits set");
  a_bit6_ignored: assert property (@(posedge mclk) disable iff (!arst_n)
    patHigh_q[PAT_HI_MASK_BIT] == 1'b0)
    else $error("pattern high bit 6 stored");
  a_count_capped: assert property (@(posedge mclk) disable iff (!arst_n)
    count_q <= 5'(WORD_BITS))
    else $error("edge count beyond word");
  a_pattern_word: assert property (@(posedge mclk) disable iff (!arst_n)
    ##1 patternWord == {$past(patHigh_q[PAT_HI_MSB:0]), $past(patLow_q)})
    else $error("pattern word mismatch");
endmodule

// File: design/amc_pkg.sv
package amc_pkg;
  // ****************************************
  // register map
  // ****************************************
  localparam logic [6:0] ADDR_RESET = 7'h00;
  localparam logic [6:0] ADDR_FMT_PWR = 7'h01;
  localparam logic [6:0] ADDR_OUT_MODE = 7'h02;
  localparam logic [6:0] ADDR_PAT_HIGH = 7'h03;
  localparam logic [6:0] ADDR_PAT_LOW = 7'h04;
  localparam logic [7:0] REG_RESET_VAL = 8'h00;

  // ****************************************
  // serial word layout
  // ****************************************
  localparam int WORD_BITS = 16;
  localparam int RW_POS = 15;
  localparam int ADDR_MSB = 14;
  localparam int ADDR_LSB = 8;
  localparam int DATA_MSB = 7;

  // ****************************************
  // field positions
  // ****************************************
  localparam int RESET_BIT = 7;
  localparam int SIGNED_BIT = 5;
  localparam int SLEEP_BIT = 4;
  localparam int NAP_MSB = 3;
  localparam int CUR_MSB = 7;
  localparam int CUR_LSB = 5;
  localparam int TERM_BIT = 4;
  localparam int OFF_BIT = 3;
  localparam int LANE_MSB = 2;
  localparam int PAT_EN_BIT = 7;
  localparam int PAT_HI_MSB = 5;
  localparam int PAT_HI_MASK_BIT = 6;
  localparam int NUM_CH = 4;
  localparam int PAT_BITS = 14;
endpackage

// File: design/amc_sync.sv
`timescale 1ns/10ps
// ****************************************
// two-flop synchroniser, per bit
// ****************************************
module amc_sync import amc_pkg::*; #(
  parameter int WIDTH = 3
) (
  // clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // data
  input wire logic [WIDTH-1:0] async,
  output logic [WIDTH-1:0] synced
);
  logic [WIDTH-1:0] meta_q;

  // first stage feeds only the second
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
          meta_q[i] <= 1'b0;
          synced[i] <= 1'b0;
        end else begin
          meta_q[i] <= async[i];
          synced[i] <= meta_q[i];
        end
      end
    end
  endgenerate
endmodule

// File: tb/adc_mode_control_registers_test.sv
`timescale 1ns/10ps
module adc_mode_control_registers_test import amc_pkg::*;;
  // ****************************************
  // signals and instances
  // ****************************************
  logic mclk, arst_n, csN, sck, sdi, sdoOut, sdoOeN;
  logic signedFormatSelect, sleepActive, internalTerminationEnable, doubleCurrent;
  logic outputDisable, patternOutputEnable;
  logic [3:0] channelPowerDown;
  logic [2:0] driverCurrentSelect, laneSerializationSelect;
  logic [13:0] patternWord;
  logic [31:0] gotOut;
  logic [7:0] m [1:4];
  int errorCnt = 0;
  int checked = 0;
  assign gotOut = {2'h0, signedFormatSelect, channelPowerDown, sleepActive, driverCurrentSelect,
    internalTerminationEnable, doubleCurrent, outputDisable, laneSerializationSelect, patternOutputEnable, patternWord};
  amc_mode_regs amc_mode_regs_inst (.mclk(mclk), .arst_n(arst_n), .csN(csN), .sck(sck), .sdi(sdi),
    .sdoOut(sdoOut), .sdoOeN(sdoOeN), .signedFormatSelect(signedFormatSelect),
    .channelPowerDown(channelPowerDown), .sleepActive(sleepActive), .driverCurrentSelect(driverCurrentSelect),
    .internalTerminationEnable(internalTerminationEnable), .doubleCurrent(doubleCurrent),
    .outputDisable(outputDisable), .laneSerializationSelect(laneSerializationSelect),
    .patternOutputEnable(patternOutputEnable), .patternWord(patternWord));
  amc_host amc_host_inst (.mclk(mclk), .csN(csN), .sck(sck), .sdi(sdi), .sdoOut(sdoOut), .sdoOeN(sdoOeN));
  // ****************************************
  // expectations and checks
  // ****************************************
  // sleep overrides the nap bits
  function automatic logic [31:0] expOut();
    return {2'h0, m[1][5], m[1][4] ? 4'hF : m[1][3:0], m[1][4], m[2][7:5], m[2][4], m[2][4], m[2][3],
      m[2][2:0], m[3][7], m[3][5:0], m[4]};
  endfunction
  // termination kept to the three highest current codes
  function automatic logic [7:0] legalMode(input logic [7:0] d);
    if (d[7:5] < 3'h5) d[4] = 1'b0;
    return d;
  endfunction
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      errorCnt++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  // write frame, model follows only a whole word to a mapped place
  task automatic wr(input logic [6:0] a, input logic [7:0] d, input int n);
    logic [7:0] rd;
    amc_host_inst.xfer({1'b0, a, d}, n, rd);
    if (n >= 16 && a >= 7'h01 && a <= 7'h04) m[a] = (a == 7'h03) ? (d & 8'hBF) : d;
    if (n >= 16 && a == 7'h00 && d[7]) m = '{default: 8'h00};
    repeat (4) @(negedge mclk);
    chk("outputs", expOut(), gotOut);
  endtask
  // read frame with junk on the data bits
  task automatic rdChk(input logic [6:0] a);
    logic [7:0] rd;
    amc_host_inst.xfer({1'b1, a, 8'($urandom)}, 16, rd);
    chk("readback", {24'h00_0000, (a >= 7'h01 && a <= 7'h04) ? m[a] : 8'h00}, {24'h00_0000, rd});
    chk("outputs", expOut(), gotOut);
  endtask
  task automatic closeOut();
    $display("checks %0d mismatches %0d", checked, errorCnt);
    if (errorCnt == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // ****************************************
  // clock, watchdog and sequence
  // ****************************************
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  // a hang costs far more than the ~15k cycles the sequence needs
  initial begin
    #400000;
    errorCnt++;
    closeOut();
  end
  initial begin
    logic [6:0] a;
    arst_n = 1'b0;
    void'($urandom(12702));
    m = '{default: 8'h00};
    repeat (16) @(negedge mclk);
    arst_n = 1'b1;
    repeat (4) @(negedge mclk);
    chk("reset", expOut(), gotOut);
    chk("sdo idle", 32'h0000_0001, {31'h0000_0000, sdoOeN});
    wr(7'h00, 8'h80, 16);
    for (int i = 0; i < 8; i++) begin
      wr(7'h02, legalMode({3'(i), 1'b1, i[0], 3'(i)}), 16);
    end
    repeat (40) begin
      a = 7'(1 + $urandom % 4);
      wr(a, (a == 7'h02) ? legalMode(8'($urandom)) : 8'($urandom), 16);
      rdChk(a);
    end
    // async reset in mid-run clears every register
    arst_n = 1'b0;
    m = '{default: 8'h00};
    repeat (2) @(negedge mclk);
    arst_n = 1'b1;
    repeat (4) @(negedge mclk);
    chk("mid reset", expOut(), gotOut);
    wr(7'h01, 8'h1A, 16);
    wr(7'h01, 8'h00, 16);
    wr(7'h03, 8'hFF, 16);
    rdChk(7'h03);
    wr(7'h04, 8'hA5, 10);
    wr(7'h04, 8'h5A, 20);
    rdChk(7'h04);
    wr(7'h55, 8'hFF, 16);
    rdChk(7'h55);
    wr(7'h00, 8'h80, 16);
    for (int i = 1; i < 5; i++) begin
      rdChk(7'(i));
    end
    closeOut();
  end
endmodule

// File: tb/amc_host.sv
`timescale 1ns/10ps
// ****************************************
// host on the serial programming port
// ****************************************
module amc_host (
  // clock
  input wire logic mclk,
  // serial port
  output logic csN,
  output logic sck,
  output logic sdi,
  input wire logic sdoOut,
  input wire logic sdoOeN
);
  logic sdoWire;
  // open drain with a pull-up, so a released line reads high
  assign sdoWire = sdoOeN ? 1'b1 : sdoOut;
  // serial clock stands low between frames
  initial begin
    csN = 1'b1;
    sck = 1'b0;
    sdi = 1'b0;
  end
  // one frame, msb first; under 16 bits aborts, over 16 adds stray edges
  task automatic xfer(input logic [15:0] w, input int nBits, output logic [7:0] rd);
    rd = 8'h00;
    @(negedge mclk);
    csN = 1'b0;
    for (int i = 0; i < nBits; i++) begin
      sdi = (i < 16) ? w[15-i] : ~sdi;
      repeat (4) @(negedge mclk);
      if (i >= 8 && i < 16) begin
        rd = {rd[6:0], sdoWire};
      end
      sck = 1'b1;
      repeat (4) @(negedge mclk);
      sck = 1'b0;
    end
    repeat (4) @(negedge mclk);
    csN = 1'b1;
    sdi = ~sdi; // undriven data: never leave the last value
    repeat (8) @(negedge mclk);
  endtask
endmodule
